// File: hdl/host_port_pkg.sv
// Constants shared by the host access port ends.
package host_port_pkg;
	localparam int DATA_W = 16;
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_ADDR = 2'h1;
	localparam logic [1:0] SEL_DATA_INC = 2'h2;
	localparam logic [1:0] SEL_DATA = 2'h3;
	localparam int STRAP_BYTE_ORDER_POS = 8;
	localparam int STRAP_LANE_POS = 12;
	localparam int STRAP_BOOT_LO_POS = 3;
	localparam logic [15:0] PULL_DEFAULT = 16'hFFEF;
	localparam logic [15:0] OPPOSABLE_MASK = 16'h8064;
	localparam logic [1:0] BOOT_HOST = 2'h0;
	localparam logic [1:0] BOOT_ROM8 = 2'h1;
	localparam logic [1:0] BOOT_ROM16 = 2'h2;
	localparam logic [1:0] BOOT_ROM32 = 2'h3;
	localparam int MEM_WORDS = 16;
	localparam int STROBE_CYCLES = 2;
	localparam logic [8:0] CTL_IDLE = 9'h01E;
	typedef enum logic [1:0]
	{
		H_IDLE = 2'b00,
		H_STROBE = 2'b01,
		H_DONE = 2'b10
	} host_state_e;
endpackage

// File: hdl/host_port_if.sv
// Pin bundle joining the host and device ends of the host access port.
`timescale 1ns/100ps
interface host_port_if;
	import host_port_pkg::*;
	logic host_irq_out;
	logic host_reg_select_hi;
	logic host_reg_select_lo;
	logic halfword_order_select;
	logic host_rw_select;
	logic host_addr_strobe_n;
	logic host_port_select_n;
	logic host_data_strobe_a_n;
	logic host_data_strobe_b_n;
	logic [15:0] hd_to_dev;
	logic [15:0] hd_from_dev;
	logic hd_dev_oe;
	logic [15:0] hd_host_out;
	logic hd_host_oe;
	assign hd_to_dev = hd_host_oe ? hd_host_out : (hd_dev_oe ? hd_from_dev : PULL_DEFAULT);
	modport device (
		output host_irq_out,
		input host_reg_select_hi,
		input host_reg_select_lo,
		input halfword_order_select,
		input host_rw_select,
		input host_addr_strobe_n,
		input host_port_select_n,
		input host_data_strobe_a_n,
		input host_data_strobe_b_n,
		input hd_to_dev,
		output hd_from_dev,
		output hd_dev_oe
	);
	modport host (
		input host_irq_out,
		output host_reg_select_hi,
		output host_reg_select_lo,
		output halfword_order_select,
		output host_rw_select,
		output host_addr_strobe_n,
		output host_port_select_n,
		output host_data_strobe_a_n,
		output host_data_strobe_b_n,
		input hd_from_dev,
		output hd_host_out,
		output hd_host_oe
	);
endinterface

// File: hdl/host_port_device.sv
// Device end of the host access port with reset strap capture.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - Data lines carry data, address, control words.
// - Host selects control, address or data register.
// - Half-word select orders the two halves.
// - Host states read or write per access.
// - Device drives host interrupt request output.
// - Straps on data lines sampled during reset.
// - Byte-order strap low big, high little.
// - Lane strap low keeps narrow data low.
// - Lane strap high big-endian uses high lane.
// - Boot strap decodes host or ROM width.
// - Host leaves non-opposable lines to pulls.
module host_port_device
	import host_port_pkg::*;
(
	input wire logic MCLK,
	input wire logic RSTN,
	host_port_if.device HP,
	input wire logic IRQ_SET,
	output logic BIG_ENDIAN,
	output logic NARROW_LANE_FIX_ENABLE,
	output logic NARROW_ON_HIGH_LANE,
	output logic [1:0] BOOT_SOURCE,
	output logic BOOT_FROM_HOST,
	output logic [1:0] BOOT_ROM_WIDTH,
	output logic STRAPS_VALID
);
	logic [15:0] hd_s1_r;
	logic [15:0] hd_s2_r;
	logic [8:0] ctl_s1_r;
	logic [8:0] ctl_s2_r;
	logic [15:0] strap_r;
	logic straps_valid_r;
	logic [15:0] ctrl_r;
	logic [31:0] addr_r;
	logic [31:0] mem_r [MEM_WORDS];
	logic [15:0] first_half_r;
	logic [15:0] rd_data_r;
	logic rd_oe_r;
	logic strobe_d_r;
	logic irq_r;
	logic [1:0] sel;
	logic hw2;
	logic rw_read;
	logic strobe;
	logic strobe_rise;
	logic wr_first;
	logic wr_commit;
	logic rd_commit;
	logic [15:0] rd_data_nxt;
	logic [3:0] widx;
	logic [31:0] word;

	// Pins are asynchronous to MCLK, so every line passes two flops first.
	// Data lines keep sampling through reset so the strap levels are already
	// in the second flop when reset is released.
	always_ff @(posedge MCLK)
	begin
		hd_s1_r <= HP.hd_to_dev;
		hd_s2_r <= hd_s1_r;
	end

	// Control lines reset to their idle levels; zeros would look like a strobe.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctl_s1_r <= CTL_IDLE;
			ctl_s2_r <= CTL_IDLE;
		end
		else
		begin
			ctl_s1_r <= {HP.host_reg_select_hi, HP.host_reg_select_lo, HP.halfword_order_select,
				HP.host_rw_select, HP.host_addr_strobe_n, HP.host_port_select_n,
				HP.host_data_strobe_a_n, HP.host_data_strobe_b_n, 1'b0};
			ctl_s2_r <= ctl_s1_r;
		end
	end

	// The first clock after release takes the levels held during reset.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			strap_r <= PULL_DEFAULT;
		else if (!straps_valid_r)
			strap_r <= hd_s2_r;
	end

	// Valid rises once and stays, which is what freezes the capture above.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			straps_valid_r <= 1'b0;
		else
			straps_valid_r <= 1'b1;
	end

	// Strap outputs come from the frozen capture, so later bus traffic never moves them.
	assign BIG_ENDIAN = ~strap_r[STRAP_BYTE_ORDER_POS];
	assign NARROW_LANE_FIX_ENABLE = strap_r[STRAP_LANE_POS];
	assign NARROW_ON_HIGH_LANE = strap_r[STRAP_LANE_POS] & ~strap_r[STRAP_BYTE_ORDER_POS];
	assign BOOT_SOURCE = strap_r[STRAP_BOOT_LO_POS+1:STRAP_BOOT_LO_POS];
	assign BOOT_FROM_HOST = (BOOT_SOURCE == BOOT_HOST);
	assign BOOT_ROM_WIDTH = BOOT_SOURCE;
	assign STRAPS_VALID = straps_valid_r;

	// Select, half and direction are taken from the synchronised copies only.
	assign sel = ctl_s2_r[8:7];
	assign hw2 = ctl_s2_r[6];
	assign rw_read = ctl_s2_r[5];
	// Either data strobe low inside an active chip select frames a transfer.
	assign strobe = ~ctl_s2_r[3] & ~(ctl_s2_r[2] & ctl_s2_r[1]);
	assign strobe_rise = strobe & ~strobe_d_r;
	assign wr_first = strobe_rise & ~rw_read & ~hw2;
	assign wr_commit = strobe_rise & ~rw_read & hw2;
	assign rd_commit = strobe_rise & rw_read & hw2;
	assign widx = addr_r[5:2];
	assign word = mem_r[widx];

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			strobe_d_r <= 1'b0;
		else
			strobe_d_r <= strobe;
	end

	// The first half only waits in a holding register until its partner arrives.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			first_half_r <= 16'h0000;
		else if (wr_first)
			first_half_r <= hd_s2_r;
	end

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			ctrl_r <= 16'h0000;
		else if (wr_commit && sel == SEL_CTRL)
			ctrl_r <= hd_s2_r;
	end

	// Auto-increment steps after the second half, on reads and writes alike.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			addr_r <= 32'h0000_0000;
		else if (wr_commit && sel == SEL_ADDR)
			addr_r <= {hd_s2_r, first_half_r};
		else if ((wr_commit || rd_commit) && sel == SEL_DATA_INC)
			addr_r <= addr_r + 32'h0000_0004;
	end

	// The store has no reset; a word must be written before it is read back.
	always_ff @(posedge MCLK)
	begin
		if (wr_commit && (sel == SEL_DATA || sel == SEL_DATA_INC))
			mem_r[widx] <= {hd_s2_r, first_half_r};
	end

	// Read word picked from the register that the select lines name.
	always_comb
	begin
		case (sel)
			SEL_CTRL: rd_data_nxt = ctrl_r;
			SEL_ADDR: rd_data_nxt = hw2 ? addr_r[31:16] : addr_r[15:0];
			default: rd_data_nxt = hw2 ? word[31:16] : word[15:0];
		endcase
	end

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			rd_oe_r <= 1'b0;
		else
			rd_oe_r <= strobe & rw_read;
	end

	// Data keep their last value between reads, so a late sample sees no change.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			rd_data_r <= 16'h0000;
		else if (strobe && rw_read)
			rd_data_r <= rd_data_nxt;
	end

	// A new event wins over a host clear written in the same cycle.
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			irq_r <= 1'b0;
		else if (IRQ_SET)
			irq_r <= 1'b1;
		else if (wr_commit && sel == SEL_CTRL && hd_s2_r[0])
			irq_r <= 1'b0;
	end

	assign HP.host_irq_out = irq_r;
	assign HP.hd_from_dev = rd_data_r;
	assign HP.hd_dev_oe = rd_oe_r;
endmodule

// File: hdl/host_port_host.sv
// Host end of the host access port, driven by a plain command port.
`timescale 1ns/100ps
module host_port_host
	import host_port_pkg::*;
(
	input wire logic MCLK,
	input wire logic RSTN,
	host_port_if.host HP,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic CMD_READ,
	input wire logic [1:0] CMD_SEL,
	input wire logic CMD_HALF2,
	input wire logic [15:0] CMD_WDATA,
	output logic RSP_VALID,
	output logic [15:0] RSP_RDATA,
	output logic IRQ
);
	host_state_e state_r;
	logic [1:0] cnt_r;
	logic read_r;
	logic [1:0] sel_r;
	logic half2_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic rsp_r;
	logic irq_s1_r;
	logic irq_s2_r;

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_s1_r <= 1'b0;
			irq_s2_r <= 1'b0;
		end
		else
		begin
			irq_s1_r <= HP.host_irq_out;
			irq_s2_r <= irq_s1_r;
		end
	end
	assign IRQ = irq_s2_r;

	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_r <= H_IDLE;
			cnt_r <= 2'h0;
			read_r <= 1'b0;
			sel_r <= 2'h0;
			half2_r <= 1'b0;
			wdata_r <= 16'h0000;
			rdata_r <= 16'h0000;
			rsp_r <= 1'b0;
		end
		else
		begin
			rsp_r <= 1'b0;
			case (state_r)
				H_IDLE:
					if (CMD_VALID)
					begin
						read_r <= CMD_READ;
						sel_r <= CMD_SEL;
						half2_r <= CMD_HALF2;
						wdata_r <= CMD_WDATA;
						cnt_r <= 2'h0;
						state_r <= H_STROBE;
					end
				H_STROBE:
				begin
					// Strobe held long enough to clear the device synchronisers.
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == 2'(STROBE_CYCLES + 1))
					begin
						rdata_r <= HP.hd_from_dev;
						rsp_r <= read_r;
						state_r <= H_DONE;
					end
				end
				H_DONE:
					state_r <= H_IDLE;
				default:
					state_r <= H_IDLE;
			endcase
		end
	end

	assign CMD_READY = (state_r == H_IDLE);
	assign RSP_VALID = rsp_r;
	assign RSP_RDATA = rdata_r;
	assign HP.host_reg_select_hi = sel_r[1];
	assign HP.host_reg_select_lo = sel_r[0];
	assign HP.halfword_order_select = half2_r;
	assign HP.host_rw_select = read_r;
	assign HP.host_addr_strobe_n = 1'b1;
	assign HP.host_port_select_n = ~(state_r == H_STROBE);
	assign HP.host_data_strobe_a_n = ~(state_r == H_STROBE);
	assign HP.host_data_strobe_b_n = 1'b1;
	assign HP.hd_host_out = wdata_r;
	// Host stays off the lines out of transfers so straps see only pulls.
	assign HP.hd_host_oe = (state_r == H_STROBE) & ~read_r;
endmodule

// File: verif/host_port_props.sv
// Checker for the pins between the two ends of the host access port.
`timescale 1ns/100ps
module host_port_props
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic host_reg_select_hi,
	input wire logic host_reg_select_lo,
	input wire logic halfword_order_select,
	input wire logic host_rw_select,
	input wire logic host_port_select_n,
	input wire logic host_data_strobe_a_n,
	input wire logic host_irq_out,
	input wire logic [15:0] hd_host_out,
	input wire logic hd_host_oe,
	input wire logic hd_dev_oe
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	one_driver_a: assert property (!(hd_dev_oe && hd_host_oe)) else $error("data bus contention");
	dev_reads_a: assert property ($rose(hd_dev_oe) |-> host_rw_select) else $error("device drove on a write");
	host_writes_a: assert property (hd_host_oe |-> !host_rw_select) else $error("host drove on a read");
	strobe_select_a: assert property (!host_data_strobe_a_n |-> !host_port_select_n) else $error("strobe unselected");
	select_stable_a: assert property (!host_data_strobe_a_n && $past(!host_data_strobe_a_n) |->
		$stable({host_reg_select_hi, host_reg_select_lo, halfword_order_select, host_rw_select}))
		else $error("select moved in strobe");
	strobe_width_a: assert property ($fell(host_data_strobe_a_n) |-> ##1 !host_data_strobe_a_n ##[1:8]
		host_data_strobe_a_n) else $error("strobe width wrong");
	wdata_stable_a: assert property (hd_host_oe && $past(hd_host_oe) |-> $stable(hd_host_out))
		else $error("write data moved");
	read_answer_a: assert property ($fell(host_data_strobe_a_n) && host_rw_select |-> ##[1:6] hd_dev_oe)
		else $error("read not answered");
	cover property ($fell(host_data_strobe_a_n) && host_rw_select);
	cover property ($fell(host_data_strobe_a_n) && hd_host_oe);
	cover property ($rose(host_irq_out));
endmodule

// File: verif/testbench.sv
// Testbench joining both ends of the host access port plus a strap rig.
`timescale 1ns/100ps
module testbench;
	import host_port_pkg::*;
	logic mclk = 0, rstn = 0, rst2n = 0, irq_set = 0, cmd_valid = 0, cmd_read = 0, cmd_half2 = 0;
	logic [1:0] cmd_sel = 0;
	logic [15:0] cmd_wdata = 0;
	logic cmd_ready, rsp_valid, irq, big, fix, high, host_boot, valid2;
	logic [1:0] boot, width;
	logic [15:0] rsp_rdata, s;
	logic [15:0] mem [8];
	logic [15:0] expq [$];
	int errors = 0, compares = 0;
	host_port_if hp();
	host_port_if hp2();
	host_port_device host_port_device_i(.MCLK(mclk), .RSTN(rstn), .HP(hp.device), .IRQ_SET(irq_set),
		.BIG_ENDIAN(), .NARROW_LANE_FIX_ENABLE(), .NARROW_ON_HIGH_LANE(), .BOOT_SOURCE(),
		.BOOT_FROM_HOST(), .BOOT_ROM_WIDTH(), .STRAPS_VALID());
	host_port_device host_port_device_i2(.MCLK(mclk), .RSTN(rst2n), .HP(hp2.device), .IRQ_SET(1'b0),
		.BIG_ENDIAN(big), .NARROW_LANE_FIX_ENABLE(fix), .NARROW_ON_HIGH_LANE(high), .BOOT_SOURCE(boot),
		.BOOT_FROM_HOST(host_boot), .BOOT_ROM_WIDTH(width), .STRAPS_VALID(valid2));
	host_port_host host_port_host_i(.MCLK(mclk), .RSTN(rstn), .HP(hp.host), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_READ(cmd_read), .CMD_SEL(cmd_sel), .CMD_HALF2(cmd_half2),
		.CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .IRQ(irq));
	host_port_props host_port_props_i(.MCLK(mclk), .RSTN(rstn), .host_reg_select_hi(hp.host_reg_select_hi),
		.host_reg_select_lo(hp.host_reg_select_lo), .halfword_order_select(hp.halfword_order_select),
		.host_rw_select(hp.host_rw_select), .host_port_select_n(hp.host_port_select_n),
		.host_data_strobe_a_n(hp.host_data_strobe_a_n), .host_irq_out(hp.host_irq_out),
		.hd_host_out(hp.hd_host_out), .hd_host_oe(hp.hd_host_oe), .hd_dev_oe(hp.hd_dev_oe));
	initial
	begin
		forever #20 mclk = !mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// The command is taken at the first edge whose sampled ready is high.
	task cmd(input logic rd, input logic [1:0] sel, input logic h2, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		cmd_valid <= 1;
		cmd_read <= rd;
		cmd_sel <= sel;
		cmd_half2 <= h2;
		cmd_wdata <= wd;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (cmd_ready !== 1 && n < 40);
		if (n >= 40)
		begin
			errors++;
			close_out;
		end
		else
			cmd_valid <= 0;
	endtask
	task wait_irq(input logic want);
		int n;
		for (n = 0; n < 20 && irq !== want; n++)
			@(posedge mclk);
		check(irq, want);
	endtask
	always @(posedge mclk)
		if (rsp_valid === 1)
		begin
			if (expq.size() > 0)
				check(rsp_rdata, expq.pop_front());
			else
			begin
				errors++;
				$display("ERROR %0t read answer with nothing expected", $time);
			end
		end
	initial
	begin
		int i;
		{hp2.host_reg_select_hi, hp2.host_reg_select_lo, hp2.halfword_order_select, hp2.host_rw_select} = 4'h0;
		{hp2.host_addr_strobe_n, hp2.host_port_select_n, hp2.host_data_strobe_a_n} = 3'h7;
		{hp2.host_data_strobe_b_n, hp2.hd_host_oe} = 2'h3;
		hp2.hd_host_out = PULL_DEFAULT;
		void'($urandom(66883));
		repeat (6) @(posedge mclk);
		rstn <= 1;
		for (i = 0; i < 20; i++)
		begin
			if (i == 0 || i == 10)
			begin
				cmd(0, SEL_ADDR, 0, 16'h0000);
				cmd(0, SEL_ADDR, 1, 16'h0000);
			end
			if (i < 10)
				mem[i % 8] = (i < 8) ? 16'($urandom) : mem[i % 8];
			if (i >= 10)
				expq.push_back(mem[(i - 10) % 8]);
			cmd(i >= 10, (i % 10 < 8) ? SEL_DATA_INC : SEL_DATA, i[0], mem[i % 8]);
		end
		// The last two plain-data passes rewrite and reread the fifth word without stepping.
		@(posedge mclk);
		irq_set <= 1;
		@(posedge mclk);
		irq_set <= 0;
		wait_irq(1);
		cmd(0, SEL_CTRL, 0, 16'h0000);
		cmd(0, SEL_CTRL, 1, 16'h0001);
		wait_irq(0);
		for (i = 0; i < 8; i++)
		begin
			s = PULL_DEFAULT ^ (16'($urandom) & OPPOSABLE_MASK);
			s[STRAP_BOOT_LO_POS +: 2] = i[1:0];
			s[STRAP_BYTE_ORDER_POS] = i[2];
			s[STRAP_LANE_POS] = 1'($urandom);
			rst2n <= 0;
			hp2.hd_host_out <= s;
			repeat (3) @(posedge mclk);
			rst2n <= 1;
			repeat (2) @(posedge mclk);
			hp2.hd_host_out <= ~s;
			repeat (2) @(posedge mclk);
			check(valid2, 1);
			check(big, !s[STRAP_BYTE_ORDER_POS]);
			check(fix, s[STRAP_LANE_POS]);
			check(high, s[STRAP_LANE_POS] & !s[STRAP_BYTE_ORDER_POS]);
			check(boot, i[1:0]);
			check(host_boot, i[1:0] == 0);
			if (i[1:0] != 0)
				check(width, i[1:0]);
		end
		for (i = 0; i < 100 && expq.size() > 0; i++)
			@(posedge mclk);
		errors += expq.size();
		close_out;
	end
endmodule
